// ===== rtl/cbl_timing.sv
// Operation
// - counter steps once per transport period
// - start count at least 81 transport periods
// - clamp two counts wide, states 75 and 74, or 196 and 195 when extended
// - long exposure start value becomes 202
// - sample decoded at state 132 when extended
// - decodes taken from both counter stages
// - switches toggle exactly at dark-reference pixels
// - clamp and sample use separate intervals
// - correction repeats at dark-reference rate
// - sample and correction every readout cycle
// - convert strobe positive, nominally 30 ns; the code drives it for one 25 ns master cycle
// - strobe leads sample point by 10 ns
// - strobe ends where reset clock begins
// - strobe is phase d and delayed b
// - delayed b keeps strobe 40 ns or less
// - extra delay aligns strobe with reset clock
// - divide by four phases, then transport divide
// - clamp open except pre-data dark pixels
`timescale 1ns/1ps
`default_nettype none

module cbl_timing (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic long_exposure,
  output logic      output_reset_clock,
  output logic      transport_clock,
  output logic      line_transfer_clock,
  output logic      white_ref_clock,
  output logic      clamp_switch_ctrl,
  output logic      sample_switch_ctrl,
  output logic      convert_strobe
);

  // ========================================================
  // quadrature phase divider
  // ========================================================
  cbl_pkg::cbl_phase_t phase_q;
  cbl_pkg::cbl_phase_t phase_d;
  logic                ph_a;
  logic                ph_b;
  logic                ph_d;

  // divide by four into four quadrature-complementary phases
  always_comb begin
    case (phase_q)
      cbl_pkg::CBL_PH_00: phase_d = cbl_pkg::CBL_PH_01;
      cbl_pkg::CBL_PH_01: phase_d = cbl_pkg::CBL_PH_11;
      cbl_pkg::CBL_PH_11: phase_d = cbl_pkg::CBL_PH_10;
      cbl_pkg::CBL_PH_10: phase_d = cbl_pkg::CBL_PH_00;
      default:            phase_d = cbl_pkg::CBL_PH_00;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase_q <= cbl_pkg::CBL_PH_00;
    end else begin
      phase_q <= phase_d;
    end
  end

  // phase c is the complement of a and is not needed here
  assign ph_a = phase_q[0];
  assign ph_b = phase_q[1];
  assign ph_d = ~phase_q[1];

  // ========================================================
  // long exposure pin synchroniser
  // ========================================================
  logic ext_sy1_q;
  logic ext_sy2_q;
  logic ext_sy3_q;
  logic ext_lvl_q;
  logic ext_lvl_d;

  // level only moves once the last two stages agree
  always_comb begin
    ext_lvl_d = ext_lvl_q;
    if (ext_sy2_q == ext_sy3_q) begin
      ext_lvl_d = ext_sy3_q;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ext_sy1_q <= 1'b0;
      ext_sy2_q <= 1'b0;
      ext_sy3_q <= 1'b0;
      ext_lvl_q <= 1'b0;
    end else begin
      ext_sy1_q <= long_exposure;
      ext_sy2_q <= ext_sy1_q;
      ext_sy3_q <= ext_sy2_q;
      ext_lvl_q <= ext_lvl_d;
    end
  end

  // ========================================================
  // transport clock and exposure down counter
  // ========================================================
  logic       pix_edge;
  logic       step;
  logic       term;
  logic       tck_q;
  logic       tck_d;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       mode_q;
  logic       mode_d;
  logic [7:0] start_val;

  // pixel boundary sits where phase a rises, so the transport
  // clock edge lines up with the reset clock rise
  assign pix_edge = (phase_q == cbl_pkg::CBL_PH_01);
  assign step     = pix_edge & ~tck_q;
  assign term     = (cnt_q == cbl_pkg::CNT_TERM);
  // mode changes only at reload so a frame never mixes decodes
  assign start_val = ext_lvl_q ? cbl_pkg::START_EXT : cbl_pkg::START_BASE;

  always_comb begin
    tck_d  = pix_edge ? ~tck_q : tck_q;
    cnt_d  = cnt_q;
    mode_d = mode_q;
    if (step) begin
      if (term) begin
        mode_d = ext_lvl_q;
        cnt_d  = start_val;
      end else begin
        cnt_d  = cnt_q - 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tck_q  <= 1'b0;
      cnt_q  <= 8'h00;
      mode_q <= 1'b0;
    end else begin
      tck_q  <= tck_d;
      cnt_q  <= cnt_d;
      mode_q <= mode_d;
    end
  end

  // ========================================================
  // black-level switch decode and transfer pulses
  // ========================================================
  logic clamp_hit;
  logic sample_hit;
  logic xfer_q;
  logic xfer_d;
  logic wref_q;
  logic wref_d;
  logic clamp_q;
  logic clamp_d;
  logic sample_q;
  logic sample_d;

  // full eight bits span both four-bit stages of the counter chain;
  // clamp and sample sit on different counts because the clamp
  // disturbs the signal the sample would measure
  always_comb begin
    if (mode_q) begin
      clamp_hit  = (cnt_q == cbl_pkg::CLAMP_HI_EXT) | (cnt_q == cbl_pkg::CLAMP_LO_EXT);
      sample_hit = (cnt_q == cbl_pkg::SAMPLE_EXT);
    end else begin
      clamp_hit  = (cnt_q == cbl_pkg::CLAMP_HI) | (cnt_q == cbl_pkg::CLAMP_LO);
      sample_hit = (cnt_q == cbl_pkg::SAMPLE_BASE);
    end
  end

  // every frame in one mode repeats the same decodes, so correction runs each readout
  always_comb begin
    xfer_d   = step ? term : xfer_q;
    wref_d   = xfer_d & tck_d;  // first transport half only
    clamp_d  = clamp_hit;
    sample_d = sample_hit;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      xfer_q   <= 1'b0;
      wref_q   <= 1'b0;
      clamp_q  <= 1'b0;
      sample_q <= 1'b0;
    end else begin
      xfer_q   <= xfer_d;
      wref_q   <= wref_d;
      clamp_q  <= clamp_d;
      sample_q <= sample_d;
    end
  end

  // ========================================================
  // reset clock and converter strobe
  // ========================================================
  logic b_dly_q;
  logic rclk_q;
  logic strobe_q;
  logic strobe_d;

  // the flop on b stands in for the gate delay; reset clock and
  // strobe both pass one more flop so their relative timing holds
  always_comb begin
    strobe_d = ph_d & b_dly_q;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      b_dly_q  <= 1'b0;
      rclk_q   <= 1'b0;
      strobe_q <= 1'b0;
    end else begin
      b_dly_q  <= ph_b;
      rclk_q   <= ph_a;
      strobe_q <= strobe_d;
    end
  end

  assign output_reset_clock  = rclk_q;
  assign transport_clock     = tck_q;
  assign line_transfer_clock = xfer_q;
  assign white_ref_clock     = wref_q;
  assign clamp_switch_ctrl   = clamp_q;
  assign sample_switch_ctrl  = sample_q;
  assign convert_strobe      = strobe_q;

  // ========================================================
  // assertions
  // ========================================================
  property p_phase_seq;
    @(posedge clk) disable iff (!rstn)
      (phase_q == cbl_pkg::CBL_PH_00) |=> (phase_q == cbl_pkg::CBL_PH_01) ##1
      (phase_q == cbl_pkg::CBL_PH_11) ##1 (phase_q == cbl_pkg::CBL_PH_10);
  endproperty
  a_phase_seq: assert property (p_phase_seq) else $error("phase order broken");

  property p_cnt_step;
    @(posedge clk) disable iff (!rstn)
      (cnt_q != $past(cnt_q)) |-> $past(step) && $past(tck_q) == 1'b0;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("counter moved off transport edge");

  property p_reload;
    @(posedge clk) disable iff (!rstn)
      (step && term) |=> xfer_q && (cnt_q >= cbl_pkg::START_BASE);
  endproperty
  a_reload: assert property (p_reload) else $error("terminal count did not reload");

  property p_start_min;
    @(posedge clk) disable iff (!rstn)
      $rose(xfer_q) |-> (cnt_q == cbl_pkg::START_BASE) || (cnt_q == cbl_pkg::START_EXT);
  endproperty
  a_start_min: assert property (p_start_min) else $error("bad start value");

  property p_clamp_width;
    @(posedge clk) disable iff (!rstn)
      $rose(clamp_q) |-> clamp_q [*8] ##1 clamp_q [*8] ##1 !clamp_q;
  endproperty
  a_clamp_width: assert property (p_clamp_width) else $error("clamp not four pixels");

  property p_clamp_state;
    @(posedge clk) disable iff (!rstn)
      clamp_q |-> $past(cnt_q) == (mode_q ? cbl_pkg::CLAMP_HI_EXT : cbl_pkg::CLAMP_HI)
               || $past(cnt_q) == (mode_q ? cbl_pkg::CLAMP_LO_EXT : cbl_pkg::CLAMP_LO);
  endproperty
  a_clamp_state: assert property (p_clamp_state) else $error("clamp outside dark pixels");

  property p_sample_state;
    @(posedge clk) disable iff (!rstn)
      sample_q |-> $past(cnt_q) == (mode_q ? cbl_pkg::SAMPLE_EXT : cbl_pkg::SAMPLE_BASE);
  endproperty
  a_sample_state: assert property (p_sample_state) else $error("sample at wrong count");

  property p_separate;
    @(posedge clk) disable iff (!rstn)
      !(clamp_q && sample_q);
  endproperty
  a_separate: assert property (p_separate) else $error("clamp and sample overlap");

  property p_strobe_shape;
    @(posedge clk) disable iff (!rstn)
      $rose(strobe_q) |=> !strobe_q [*3] ##1 strobe_q;
  endproperty
  a_strobe_shape: assert property (p_strobe_shape) else $error("strobe too wide");

  property p_strobe_end;
    @(posedge clk) disable iff (!rstn)
      $fell(strobe_q) |-> $rose(rclk_q);
  endproperty
  a_strobe_end: assert property (p_strobe_end) else $error("strobe end not at reset clock");

  property p_strobe_src;
    @(posedge clk) disable iff (!rstn)
      strobe_q |-> $past(phase_q) == cbl_pkg::CBL_PH_00 && !rclk_q;
  endproperty
  a_strobe_src: assert property (p_strobe_src) else $error("strobe decode wrong");

  property p_tck_align;
    @(posedge clk) disable iff (!rstn)
      (tck_q != $past(tck_q)) |-> $rose(rclk_q);
  endproperty
  a_tck_align: assert property (p_tck_align) else $error("transport edge off reset rise");

endmodule : cbl_timing

`default_nettype wire

// ===== shared/cbl_pkg.sv
// ==========================================================
// shared constants for the ccd black-level and convert timing
// ==========================================================
`default_nettype none
package cbl_pkg;

  // ========================================================
  // master clock and converter strobe timing
  // ========================================================
  localparam int unsigned CLK_PERIOD_PS  = 25000;  // 40 mhz master oscillator
  localparam int unsigned STROBE_NOM_PS  = 30000;  // nominal convert strobe width
  localparam int unsigned STROBE_MAX_PS  = 40000;  // strobe must stay at or below this
  localparam int unsigned STROBE_LEAD_PS = 10000;  // strobe lead ahead of sample point
  // nominal width rounds down, never below one cycle
  localparam int unsigned STROBE_CYC =
    (STROBE_NOM_PS / CLK_PERIOD_PS) < 1 ? 1 : (STROBE_NOM_PS / CLK_PERIOD_PS);
  localparam int unsigned STROBE_MAX_CYC = STROBE_MAX_PS / CLK_PERIOD_PS;

  // ========================================================
  // divider structure
  // ========================================================
  localparam int unsigned PIX_CYC = 4;             // master cycles per pixel
  localparam int unsigned TCK_CYC = 2 * PIX_CYC;   // master cycles per transport period

  // quadrature phase states, gray order so each step flips one bit
  typedef enum logic [1:0] {
    CBL_PH_00 = 2'b00,
    CBL_PH_01 = 2'b01,
    CBL_PH_11 = 2'b11,
    CBL_PH_10 = 2'b10
  } cbl_phase_t;

  // ========================================================
  // exposure down counter and decode states
  // ========================================================
  localparam int unsigned CNT_W        = 8;
  localparam logic [7:0]  START_BASE   = 8'h51;  // 81 transport counts
  localparam logic [7:0]  START_EXT    = 8'hca;  // 202 with lengthened exposure
  localparam logic [7:0]  EXP_ADD      = 8'h80;  // 128 added for long exposure
  localparam logic [7:0]  CLAMP_HI     = 8'h4b;  // 75, clamp window first state
  localparam logic [7:0]  CLAMP_LO     = 8'h4a;  // 74, clamp window last state
  localparam logic [7:0]  SAMPLE_BASE  = 8'h04;  // 4, sample state before offset
  localparam logic [7:0]  CNT_TERM     = 8'h00;  // terminal count
  localparam logic [7:0]  MIN_PIXELS   = 8'ha1;  // 161 pixel periods per readout
  // clamp window shifts with the start value
  localparam logic [7:0]  CLAMP_SHIFT  = START_EXT - START_BASE;
  localparam logic [7:0]  CLAMP_HI_EXT = CLAMP_HI + CLAMP_SHIFT;
  localparam logic [7:0]  CLAMP_LO_EXT = CLAMP_LO + CLAMP_SHIFT;
  localparam logic [7:0]  SAMPLE_EXT   = SAMPLE_BASE + EXP_ADD;  // 132

endpackage : cbl_pkg
`default_nettype wire

// ===== bench/cbl_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// flash converter as seen from the strobe
// ========================================
module cbl_conv_model (
  input  wire logic     rstn,
  input  wire logic     convert_strobe,
  output var  logic [3:0] code,
  output var  int       samples
);
  int level_mv;  // size of the negative input level, 0 to 1000 mv
  // reads its input late, so a strobe placed too late samples the next pixel
  always @(posedge convert_strobe or negedge rstn) begin
    if (!rstn) begin
      samples = 0;
      level_mv = 0;
      code = 4'h0;
    end else begin
      #10;
      code = 4'((level_mv * 15) / 1000);
      samples = samples + 1;
      level_mv = (level_mv + 67) % 1001;
    end
  end
endmodule : cbl_conv_model
`default_nettype wire

// ===== bench/cbl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ccd_black_level_and_convert_timing_tb_top;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic       long_exposure = 1'b0;
  logic       rclk, tck, xfer, wref, clamp, samp, strobe;
  logic [3:0] code;
  int         samples;
  int         fails = 0;
  int         total_checks = 0;
  int         f_len, f_tck, f_cl_on, f_cl_w, f_sa_on, f_sa_w, f_wr_w, f_xf_w, f_st;

  always #12.5 clk = ~clk;

  cbl_timing dut (.clk(clk), .rstn(rstn), .long_exposure(long_exposure),
    .output_reset_clock(rclk), .transport_clock(tck), .line_transfer_clock(xfer),
    .white_ref_clock(wref), .clamp_switch_ctrl(clamp), .sample_switch_ctrl(samp),
    .convert_strobe(strobe));
  cbl_conv_model conv (.rstn(rstn), .convert_strobe(strobe), .code(code), .samples(samples));

  // ========================================
  // reporting
  // ========================================
  task automatic stop_test;
    if (fails == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic chk_bit(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s", $time, what);
    end
  endtask : chk_bit

  task automatic chk_num(input int got, input int exp, input string what);
    total_checks++;
    if (got != exp) begin
      fails++;
      $display("BAD %0t %s got %0d want %0d", $time, what, got, exp);
    end
  endtask : chk_num

  // look just after the edge so registered outputs have settled
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick

  // ========================================
  // frame measurement
  // ========================================
  task automatic sync_frame;
    logic prev;
    int   n;
    n = 0;
    prev = xfer;
    tick();
    while (!(xfer === 1'b1 && prev === 1'b0) && n < 2000) begin
      prev = xfer;
      tick();
      n++;
    end
    chk_num(int'(n < 2000), 1, "no transfer pulse");
  endtask : sync_frame

  // starts on the cycle where the transfer pulse rose, ends on the next one
  task automatic measure_frame;
    logic px, pt;
    int   s0;
    f_len = 0;
    f_tck = 0;
    f_cl_w = 0;
    f_sa_w = 0;
    f_wr_w = 0;
    f_xf_w = 0;
    f_cl_on = -1;
    f_sa_on = -1;
    s0 = samples;
    pt = 1'b0;
    do begin
      if (xfer === 1'b1) f_xf_w++;
      if (wref === 1'b1) f_wr_w++;
      if (clamp === 1'b1) f_cl_w++;
      if (samp === 1'b1) f_sa_w++;
      if (clamp === 1'b1 && f_cl_on < 0) f_cl_on = f_len;
      if (samp === 1'b1 && f_sa_on < 0) f_sa_on = f_len;
      if (tck === 1'b1 && pt === 1'b0) f_tck++;
      pt = tck;
      px = xfer;
      tick();
      f_len++;
    end while (!(xfer === 1'b1 && px === 1'b0) && f_len < 3000);
    f_st = samples - s0;
  endtask : measure_frame

  // decode outputs lag the counter by one clock, hence the +1 on the clamp and sample starts
  task automatic check_frame(input int start, input int cl_state, input int sa_state);
    chk_num(f_tck, start + 1, "transport steps");
    chk_num(f_len, (start + 1) * cbl_pkg::TCK_CYC, "frame length");
    chk_num(f_xf_w, cbl_pkg::TCK_CYC, "transfer width");
    chk_num(f_wr_w, cbl_pkg::PIX_CYC, "white ref width");
    chk_num(f_cl_on, (start - cl_state) * cbl_pkg::TCK_CYC + 1, "clamp start");
    chk_num(f_cl_w, 2 * cbl_pkg::TCK_CYC, "clamp width");
    chk_num(f_sa_on, (start - sa_state) * cbl_pkg::TCK_CYC + 1, "sample start");
    chk_num(f_sa_w, cbl_pkg::TCK_CYC, "sample width");
    chk_num(f_st, f_len / cbl_pkg::PIX_CYC, "conversions per frame");
  endtask : check_frame

  // ========================================
  // scenarios
  // ========================================
  task automatic test_divider;
    int n;
    n = 0;
    while (strobe !== 1'b1 && n < 8) begin
      tick();
      n++;
    end
    for (int i = 0; i < 8; i++) begin
      chk_bit(strobe, 1'((i % 4) == 0), "strobe phase");
      chk_bit(rclk, 1'((i % 4) == 1 || (i % 4) == 2), "reset clock phase");
      tick();
    end
  endtask : test_divider

  task automatic test_base;
    sync_frame();
    measure_frame();
    check_frame(cbl_pkg::START_BASE, cbl_pkg::CLAMP_HI, cbl_pkg::SAMPLE_BASE);
  endtask : test_base

  // the pin rises mid-frame, so that frame must keep the short count
  task automatic test_long;
    fork
      begin
        repeat (100) @(posedge clk);
        long_exposure <= 1'b1;
      end
      measure_frame();
    join
    check_frame(cbl_pkg::START_BASE, cbl_pkg::CLAMP_HI, cbl_pkg::SAMPLE_BASE);
    for (int k = 0; k < 2; k++) begin
      measure_frame();
      check_frame(cbl_pkg::START_EXT, cbl_pkg::CLAMP_HI_EXT, cbl_pkg::SAMPLE_EXT);
    end
  endtask : test_long

  task automatic test_reset;
    repeat (300) @(posedge clk);
    rstn <= 1'b0;
    tick();
    chk_bit(clamp | samp | xfer | wref, 1'b0, "frame outputs in reset");
    chk_bit(strobe | rclk | tck, 1'b0, "divider outputs in reset");
    @(posedge clk);
    rstn <= 1'b1;
    test_divider();
    // pin still high: first frame after reset is short, the next one long
    sync_frame();
    measure_frame();
    check_frame(cbl_pkg::START_EXT, cbl_pkg::CLAMP_HI_EXT, cbl_pkg::SAMPLE_EXT);
  endtask : test_reset

  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    test_divider();
    test_base();
    test_long();
    test_reset();
    stop_test();
  end

  // about twice the expected run length
  initial begin
    #400000;
    fails++;
    stop_test();
  end
endmodule : ccd_black_level_and_convert_timing_tb_top
`default_nettype wire
